/* pwm_top.sv */
// Top of the PWM block with its AXI4-Lite register slave.
`timescale 1ns/1ps
module pwm_top (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic sleep_i,
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output logic [1:0] pin_o,
    output logic [1:0] pin_oe_o
);
    localparam int N = pwm_pkg::NUM_CH;

    // ****************************************
    // Register state
    // ****************************************
    logic [7:0] timer_ctrl_reg;
    logic [7:0] period_reg;
    logic [7:0] count_reg;
    logic [1:0] fine_reg;
    logic match_flag_reg;
    logic [N-1:0] port_latch_reg;
    logic [N-1:0] dir_reg;
    logic [7:0] ctrl_reg [N];
    logic [7:0] duty_hi_reg [N];
    logic [1:0] duty_lo_reg [N];
    logic [N-1:0] level;
    logic step;
    logic run;
    logic tick;
    logic wrap;

    // ****************************************
    // Time base
    // ****************************************
    assign run = timer_ctrl_reg[pwm_pkg::TCTRL_RUN_BIT] && !sleep_i;
    assign tick = step && (fine_reg == 2'h3);
    assign wrap = tick && (count_reg == period_reg);

    pwm_prescaler u_prescaler (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .run_i(run),
        .select_i(timer_ctrl_reg[1:0]),
        .step_o(step)
    );

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fine_reg <= 2'h0;
        end else if (step) begin
            fine_reg <= fine_reg + 2'h1;
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            count_reg <= pwm_pkg::RESET_BYTE;
        end else if (wrap) begin
            count_reg <= 8'h00;
        end else if (tick) begin
            count_reg <= count_reg + 8'h01;
        end
    end

    // ****************************************
    // Channels
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_ch
            pwm_channel u_channel (
                .clock_i(clock_i),
                .rstn_i(rstn_i),
                .step_i(step),
                .wrap_i(wrap),
                .base_i({count_reg, fine_reg}),
                .period_i(period_reg),
                .duty_i({duty_hi_reg[g], duty_lo_reg[g]}),
                .enable_i(ctrl_reg[g][pwm_pkg::CTRL_EN_BIT]),
                .level_o(level[g])
            );
        end
    endgenerate

    function automatic logic pin_value(input logic [7:0] ctrl, input logic lvl,
                                       input logic latch);
        if (ctrl[pwm_pkg::CTRL_OE_BIT]) begin
            pin_value = lvl ^ ctrl[pwm_pkg::CTRL_POL_BIT];
        end else begin
            pin_value = latch;
        end
    endfunction

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pin_o <= 2'h0;
            pin_oe_o <= 2'h0;
        end else begin
            for (int i = 0; i < N; i++) begin
                pin_o[i] <= pin_value(ctrl_reg[i], level[i], port_latch_reg[i]);
                pin_oe_o[i] <= !dir_reg[i];
            end
        end
    end

    // ****************************************
    // AXI4-Lite write path
    // ****************************************
    logic [7:0] aw_addr_reg;
    logic aw_held_reg;
    logic [7:0] w_data_reg;
    logic w_strb_reg;
    logic w_held_reg;
    logic do_write;
    logic wr_ok;

    function automatic logic [2:0] decode(input logic [7:0] addr, output int ch);
        logic [7:0] rel;
        rel = addr - pwm_pkg::ADDR_CH_BASE;
        ch = int'(rel[7:4]);
        decode = 3'h0;
        if (addr == pwm_pkg::ADDR_TIMER_CTRL) decode = 3'h1;
        else if (addr == pwm_pkg::ADDR_PERIOD) decode = 3'h2;
        else if (addr == pwm_pkg::ADDR_COUNT) decode = 3'h3;
        else if (addr == pwm_pkg::ADDR_FLAGS) decode = 3'h4;
        else if (addr == pwm_pkg::ADDR_PORT) decode = 3'h5;
        else if (addr >= pwm_pkg::ADDR_CH_BASE && ch < N) begin
            if (rel[3:0] == pwm_pkg::OFS_CTRL[3:0]) decode = 3'h6;
            else if (rel[3:0] == pwm_pkg::OFS_DUTY_HI[3:0]) decode = 3'h7;
            else if (rel[3:0] == pwm_pkg::OFS_DUTY_LO[3:0]) decode = 3'h0;
        end
        if (addr >= pwm_pkg::ADDR_CH_BASE && ch < N
            && rel[3:0] == pwm_pkg::OFS_DUTY_LO[3:0]) begin
            decode = 3'h0;
            ch = ch + 16;
        end
    endfunction

    int wch;
    logic [2:0] wsel;
    always_comb begin
        wch = 0;
        wsel = decode(aw_addr_reg, wch);
    end
    assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid_o;
    assign wr_ok = (wsel != 3'h0) || (wch >= 16);

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
        end else if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr_i;
        end else if (do_write) begin
            aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            w_held_reg <= 1'b0;
            w_data_reg <= 8'h00;
            w_strb_reg <= 1'b0;
        end else if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata_i[7:0];
            w_strb_reg <= s_axi_wstrb_i[0];
        end else if (do_write) begin
            w_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_axi_awready_o <= 1'b1;
            s_axi_wready_o <= 1'b1;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= pwm_pkg::RESP_OKAY;
        end else begin
            s_axi_awready_o <= !(aw_held_reg || (s_axi_awvalid_i && s_axi_awready_o))
                               || do_write;
            s_axi_wready_o <= !(w_held_reg || (s_axi_wvalid_i && s_axi_wready_o))
                              || do_write;
            if (do_write) begin
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= wr_ok ? pwm_pkg::RESP_OKAY : pwm_pkg::RESP_SLVERR;
            end else if (s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
            end
        end
    end

    // ****************************************
    // Register writes
    // ****************************************
    logic we;
    assign we = do_write && w_strb_reg;

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            timer_ctrl_reg <= pwm_pkg::RESET_BYTE;
            period_reg <= pwm_pkg::PERIOD_RESET;
            port_latch_reg <= 2'h0;
            dir_reg <= pwm_pkg::DIR_RESET[1:0];
        end else if (we) begin
            if (wsel == 3'h1) timer_ctrl_reg <= {1'b0, w_data_reg[6:0]};
            if (wsel == 3'h2) period_reg <= w_data_reg;
            if (wsel == 3'h5) begin
                port_latch_reg <= w_data_reg[1:0];
                dir_reg <= w_data_reg[5:4];
            end
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            match_flag_reg <= 1'b0;
        end else if (wrap) begin
            match_flag_reg <= 1'b1;
        end else if (we && wsel == 3'h4 && w_data_reg[0]) begin
            match_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < N; i++) begin
                ctrl_reg[i] <= pwm_pkg::RESET_BYTE;
                duty_hi_reg[i] <= pwm_pkg::RESET_BYTE;
                duty_lo_reg[i] <= 2'h0;
            end
        end else if (we) begin
            for (int i = 0; i < N; i++) begin
                if (wsel == 3'h6 && wch == i) ctrl_reg[i] <= {w_data_reg[7:6], 1'b0,
                                                               w_data_reg[4], 4'h0};
                if (wsel == 3'h7 && wch == i) duty_hi_reg[i] <= w_data_reg;
                if (wch == i + 16) duty_lo_reg[i] <= w_data_reg[7:6];
            end
        end
    end

    // ****************************************
    // AXI4-Lite read path
    // ****************************************
    int rch;
    logic [2:0] rsel;
    logic [7:0] rbyte;
    always_comb begin
        rch = 0;
        rbyte = 8'h00;
        rsel = decode(s_axi_araddr_i, rch);
        case (rsel)
            3'h1: rbyte = timer_ctrl_reg;
            3'h2: rbyte = period_reg;
            3'h3: rbyte = count_reg;
            3'h4: rbyte = {7'h00, match_flag_reg};
            3'h5: rbyte = {2'h0, dir_reg, 2'h0, port_latch_reg};
            3'h6: rbyte = ctrl_reg[rch[0]] | {2'h0, level[rch[0]], 5'h00};
            3'h7: rbyte = duty_hi_reg[rch[0]];
            default: rbyte = (rch >= 16) ? {duty_lo_reg[rch[0]], 6'h00} : 8'h00;
        endcase
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_axi_arready_o <= 1'b1;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h00000000;
            s_axi_rresp_o <= pwm_pkg::RESP_OKAY;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o <= {24'h000000, rbyte};
            s_axi_rresp_o <= (rsel != 3'h0 || rch >= 16) ? pwm_pkg::RESP_OKAY
                                                          : pwm_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_arready_o <= 1'b1;
        end
    end
endmodule // pwm_top

/* pwm_pkg.sv */
// Package of constants shared by the PWM block.
package pwm_pkg;
    localparam int NUM_CH = 2;
    localparam logic [7:0] ADDR_TIMER_CTRL = 8'h00;
    localparam logic [7:0] ADDR_PERIOD = 8'h04;
    localparam logic [7:0] ADDR_COUNT = 8'h08;
    localparam logic [7:0] ADDR_FLAGS = 8'h0C;
    localparam logic [7:0] ADDR_PORT = 8'h10;
    localparam logic [7:0] ADDR_CH_BASE = 8'h20;
    localparam logic [7:0] CH_STRIDE = 8'h10;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_DUTY_HI = 8'h04;
    localparam logic [7:0] OFS_DUTY_LO = 8'h08;
    localparam int CTRL_EN_BIT = 7;
    localparam int CTRL_OE_BIT = 6;
    localparam int CTRL_OUT_BIT = 5;
    localparam int CTRL_POL_BIT = 4;
    localparam int TCTRL_RUN_BIT = 2;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] PERIOD_RESET = 8'hFF;
    localparam logic [7:0] DIR_RESET = 8'hFF;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int CLK_PER_TICK = 4;
    typedef enum logic [1:0] {
        PS_1 = 2'h0,
        PS_4 = 2'h1,
        PS_16 = 2'h2,
        PS_64 = 2'h3
    } prescale_t;
endpackage

/* pwm_prescaler.sv */
// Prescaler that produces the time base step enable.
`timescale 1ns/1ps
module pwm_prescaler (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic run_i,
    input wire logic [1:0] select_i,
    output logic step_o
);
    logic [5:0] div_reg;
    logic [5:0] limit;

    always_comb begin
        case (pwm_pkg::prescale_t'(select_i))
            pwm_pkg::PS_1: limit = 6'h00;
            pwm_pkg::PS_4: limit = 6'h03;
            pwm_pkg::PS_16: limit = 6'h0F;
            pwm_pkg::PS_64: limit = 6'h3F;
            default: limit = 6'h00;
        endcase
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            div_reg <= 6'h00;
        end else if (!run_i) begin
            div_reg <= div_reg;
        end else if (div_reg >= limit) begin
            div_reg <= 6'h00;
        end else begin
            div_reg <= div_reg + 6'h01;
        end
    end

    assign step_o = run_i && (div_reg >= limit);
endmodule // pwm_prescaler

/* pwm_channel.sv */
// One PWM channel with buffered duty and an enable that forces the level low.
`timescale 1ns/1ps
module pwm_channel (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic step_i,
    input wire logic wrap_i,
    input wire logic [9:0] base_i,
    input wire logic [7:0] period_i,
    input wire logic [9:0] duty_i,
    input wire logic enable_i,
    output logic level_o
);
    logic [9:0] duty_buf_reg;
    logic level_reg;
    logic [9:0] period_ext;
    logic [9:0] base_next;

    assign period_ext = {period_i, 2'h0};
    // The pulse ends on the step that brings the base up to the duty value.
    assign base_next = base_i + 10'h001;

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            duty_buf_reg <= 10'h000;
        end else if (wrap_i) begin
            duty_buf_reg <= duty_i;
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            level_reg <= 1'b0;
        end else if (!enable_i) begin
            level_reg <= 1'b0;
        end else if (wrap_i) begin
            level_reg <= (duty_i != 10'h000);
        end else if (step_i && (base_next == duty_buf_reg) && (duty_buf_reg < period_ext)) begin
            level_reg <= 1'b0;
        end
    end

    assign level_o = level_reg;
endmodule // pwm_channel

/* pwm_load.sv */
// Load model on one PWM pin that measures high time and period.
`timescale 1ns/1ps
module pwm_load (
    input wire logic clock_i,
    input wire logic pin_i,
    input wire logic oe_i,
    output logic line_o,
    output logic [15:0] high_o,
    output logic [15:0] period_o,
    output logic rise_o
);
    logic [15:0] hi_reg;
    logic [15:0] all_reg;
    logic last_reg;
    // The load pulls the line low while the pin is not driven.
    assign line_o = oe_i ? pin_i : 1'b0;
    always_ff @(posedge clock_i) begin
        last_reg <= line_o;
        rise_o <= line_o && !last_reg;
        if (line_o && !last_reg) begin
            high_o <= hi_reg;
            period_o <= all_reg;
            hi_reg <= 16'h1;
            all_reg <= 16'h1;
        end else begin
            hi_reg <= hi_reg + {15'h0, line_o};
            all_reg <= all_reg + 16'h1;
        end
    end
endmodule // pwm_load

/* pwm_top_asserts.sv */
// Checker of bus answers and pin behaviour at the PWM top ports.
`timescale 1ns/1ps
module pwm_top_checker (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic sleep_i,
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic [1:0] s_axi_rresp_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic [1:0] pin_o,
    input wire logic [1:0] pin_oe_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    sequence wr_both;
        s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
    endsequence
    sequence rd_take;
        s_axi_arvalid_i && s_axi_arready_o;
    endsequence
    a_reset_quiet: assert property (
        $rose(rstn_i) |-> pin_oe_o == 2'h0 && pin_o == 2'h0 && !s_axi_bvalid_o)
        else $error("pins or response active after reset");
    a_sleep_hold: assert property (
        (sleep_i && !s_axi_wvalid_i) [*4] |-> $stable(pin_o) && $stable(pin_oe_o))
        else $error("pins changed in sleep");
    a_read_late: assert property (rd_take |=> s_axi_rvalid_o)
        else $error("read answer late");
    a_write_late: assert property (wr_both |-> ##2 s_axi_bvalid_o)
        else $error("write answer late");
    a_bresp_hold: assert property (
        s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
        else $error("write response dropped");
    a_rdata_hold: assert property (
        s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
        else $error("read data dropped");
    a_read_cause: assert property ($rose(s_axi_rvalid_o) |-> $past(rd_take))
        else $error("read answer without request");
    a_unmapped_read: assert property (
        rd_take and s_axi_araddr_i == 8'hFC |=> s_axi_rresp_o == pwm_pkg::RESP_SLVERR
        && s_axi_rdata_o == 32'h0)
        else $error("unmapped read not refused");
endmodule // pwm_top_checker
bind pwm_top pwm_top_checker chk (.clock_i, .rstn_i, .sleep_i, .s_axi_awvalid_i,
    .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
    .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
    .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .pin_o, .pin_oe_o);

/* pwm_top_bench.sv */
// Self-checking bench of the PWM top with a load model on each pin.
`timescale 1ns/1ps
module pwm_top_bench;
    logic clock_i, rstn_i, sleep_i, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, pin, oe;
    wire [1:0] line, rise;
    wire [15:0] hi_m [2];
    wire [15:0] per_m [2];
    logic [33:0] exp_q [$];
    int bad_count, n_compared, cycles, d, f;
    pwm_top dut (.clock_i(clock_i), .rstn_i(rstn_i), .sleep_i(sleep_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .pin_o(pin), .pin_oe_o(oe));
    for (genvar g = 0; g < 2; g++) begin : g_load
        pwm_load ld (.clock_i(clock_i), .pin_i(pin[g]), .oe_i(oe[g]), .line_o(line[g]),
            .high_o(hi_m[g]), .period_o(per_m[g]), .rise_o(rise[g]));
    end
    // ****
    // Bus tasks and comparisons.
    // ****
    function automatic logic [7:0] cha(input int n, input logic [7:0] o);
        return 8'(pwm_pkg::ADDR_CH_BASE + pwm_pkg::CH_STRIDE * n[7:0] + o);
    endfunction
    task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s = 4'hF,
            input logic [1:0] er = pwm_pkg::RESP_OKAY);
        logic ha, hw, bd;
        @(posedge clock_i);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= v;
        wstrb <= s;
        wvalid <= 1'b1;
        bready <= 1'b1;
        bd = 1'b0;
        while (!bd) begin
            @(negedge clock_i);
            ha = awvalid && awready;
            hw = wvalid && wready;
            bd = bvalid;
            if (bd) chk("bresp", {32'h0, er}, {32'h0, bresp});
            @(posedge clock_i);
            if (ha) awvalid <= 1'b0;
            if (hw) wvalid <= 1'b0;
            if (bd) bready <= 1'b0;
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        logic ha, done;
        exp_q.push_back(e);
        @(posedge clock_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        done = 1'b0;
        while (!done) begin
            @(negedge clock_i);
            ha = arvalid && arready;
            done = rvalid;
            @(posedge clock_i);
            if (ha) arvalid <= 1'b0;
            if (done) rready <= 1'b0;
        end
    endtask
    task automatic meas(input int c, input int hi, input int per);
        repeat (3) @(posedge rise[c]);
        @(negedge clock_i);
        chk("high time", 34'(hi), {18'h0, hi_m[c]});
        chk("period", 34'(per), {18'h0, per_m[c]});
    endtask
    task automatic hold(input int c, input logic v, input int n);
        repeat (4) @(negedge clock_i);
        repeat (n) begin
            @(negedge clock_i);
            chk("pin level", {33'h0, v}, {33'h0, line[c]});
        end
    endtask
    task automatic print_verdict();
        if (bad_count == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(negedge clock_i) begin
        if (rvalid && rready) begin
            chk("read", exp_q.pop_front(), {rresp, rdata});
        end
    end
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 50000) begin
            bad_count++;
            print_verdict();
        end
    end
    initial begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end
    // ****
    // Main sequence.
    // ****
    initial begin
        {rstn_i, sleep_i, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb, bad_count, n_compared, cycles} = '0;
        d = $urandom(32'h4AB8);
        repeat (5) @(posedge clock_i);
        rstn_i <= 1'b1;
        rd(pwm_pkg::ADDR_TIMER_CTRL, 34'h0);
        rd(pwm_pkg::ADDR_PERIOD, 34'hFF);
        rd(pwm_pkg::ADDR_PORT, 34'h30);
        rd(cha(1, pwm_pkg::OFS_DUTY_HI), 34'h0);
        rd(8'hFC, {pwm_pkg::RESP_SLVERR, 32'h0});
        wr(8'hFC, 32'h0, 4'hF, pwm_pkg::RESP_SLVERR);
        wr(cha(0, pwm_pkg::OFS_DUTY_LO), 32'hFF);
        rd(cha(0, pwm_pkg::OFS_DUTY_LO), 34'hC0);
        wr(cha(0, pwm_pkg::OFS_DUTY_LO), 32'h0, 4'h0);
        rd(cha(0, pwm_pkg::OFS_DUTY_LO), 34'hC0);
        wr(pwm_pkg::ADDR_PORT, 32'h01);
        wr(cha(1, pwm_pkg::OFS_CTRL), 32'h50);
        hold(0, 1'b1, 8);
        hold(1, 1'b1, 8);
        wr(pwm_pkg::ADDR_PORT, 32'h30);
        wr(pwm_pkg::ADDR_PERIOD, 32'h09);
        wr(pwm_pkg::ADDR_FLAGS, 32'h01);
        wr(pwm_pkg::ADDR_TIMER_CTRL, 32'h04);
        repeat (100) @(posedge clock_i);
        rd(pwm_pkg::ADDR_FLAGS, 34'h1);
        wr(pwm_pkg::ADDR_PORT, 32'h00);
        wr(cha(1, pwm_pkg::OFS_DUTY_HI), 32'h05);
        wr(cha(1, pwm_pkg::OFS_DUTY_LO), 32'h80);
        wr(cha(0, pwm_pkg::OFS_CTRL), 32'hC0);
        wr(cha(1, pwm_pkg::OFS_CTRL), 32'hD0);
        for (int ps = 0; ps < 4; ps++) begin
            d = 1 + $urandom % 35;
            f = 1 << (2 * ps);
            wr(cha(0, pwm_pkg::OFS_DUTY_HI), 32'(d >> 2));
            wr(cha(0, pwm_pkg::OFS_DUTY_LO), 32'((d & 3) << 6));
            wr(pwm_pkg::ADDR_TIMER_CTRL, 32'h7C | 32'(ps));
            meas(0, d * f, 40 * f);
            meas(1, 18 * f, 40 * f);
        end
        wr(pwm_pkg::ADDR_TIMER_CTRL, 32'h04);
        wr(cha(0, pwm_pkg::OFS_DUTY_HI), 32'hFF);
        repeat (120) @(posedge clock_i);
        hold(0, 1'b1, 100);
        wr(cha(0, pwm_pkg::OFS_DUTY_HI), 32'h00);
        wr(cha(0, pwm_pkg::OFS_DUTY_LO), 32'h00);
        repeat (120) @(posedge clock_i);
        hold(0, 1'b0, 100);
        @(posedge clock_i);
        sleep_i <= 1'b1;
        repeat (200) @(posedge clock_i);
        sleep_i <= 1'b0;
        meas(1, 18, 40);
        @(posedge clock_i);
        rstn_i <= 1'b0;
        repeat (5) @(posedge clock_i);
        rstn_i <= 1'b1;
        rd(cha(1, pwm_pkg::OFS_CTRL), 34'h0);
        rd(pwm_pkg::ADDR_COUNT, 34'h0);
        rd(pwm_pkg::ADDR_PORT, 34'h30);
        hold(1, 1'b0, 8);
        print_verdict();
    end
endmodule // pwm_top_bench
